//--- fmc_pkg.sv
package fmc_pkg;
   // Array geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 16;
   localparam int LARGE_SECTORS = 31;
   localparam int SMALL_SECTORS = 8;
   localparam int SECTOR_COUNT = 39;
   localparam int LARGE_SHIFT = 15;
   localparam int SMALL_SHIFT = 12;
   localparam logic [5:0] SECT_W6 = 6'h27;
   // Timing in ns and derived cycle counts at 200 MHz
   localparam int CLK_NS = 5;
   localparam int T_WE_LOW_NS = 50;
   localparam int T_WE_HIGH_NS = 30;
   localparam int T_READ_NS = 70;
   localparam int T_RST_LOW_NS = 500;
   localparam int T_RST_REC_NS = 50;
   localparam int WE_LOW_CYC = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int WE_HIGH_CYC = (T_WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
   localparam int READ_CYC = (T_READ_NS + CLK_NS - 1) / CLK_NS + 1;
   localparam int RST_LOW_CYC = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
   localparam int RST_REC_CYC = (T_RST_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 8;
   // Unlock addresses and command codes
   localparam logic [ADDR_W-1:0] UNLOCK_A1 = 20'h0_0555;
   localparam logic [ADDR_W-1:0] UNLOCK_A2 = 20'h0_0AAA;
   localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00AA;
   localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
   localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00A0;
   localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CMD_SECTOR = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_CHIP = 16'h0010;
   localparam logic [DATA_W-1:0] CMD_SUSPEND = 16'h00B0;
   localparam logic [DATA_W-1:0] CMD_RESUME = 16'h0030;
   localparam logic [DATA_W-1:0] CMD_SPM = 16'h0070;
   localparam logic [DATA_W-1:0] CMD_LOCK = 16'h0060;
   // Host commands
   typedef enum logic [3:0] {
      FMC_OP_READ,
      FMC_OP_PROGRAM,
      FMC_OP_SECTOR_ERASE,
      FMC_OP_CHIP_ERASE,
      FMC_OP_SUSPEND,
      FMC_OP_RESUME,
      FMC_OP_SPM_ENTER,
      FMC_OP_SPM_EXIT,
      FMC_OP_LOCK_SECTOR
   } fmc_op_t;
   typedef enum logic [3:0] {
      FMC_IDLE,
      FMC_WR_SETUP,
      FMC_WR_LOW,
      FMC_WR_HIGH,
      FMC_RD_LOW,
      FMC_RST_LOW,
      FMC_RST_REC,
      FMC_DONE
   } fmc_state_t;
endpackage

//--- fmc_ctrl.sv
`timescale 1ns/1ps
module fmc_ctrl
   import fmc_pkg::*;
#(
   parameter bit BOOT_TOP = 1'b1
)
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic req_valid,
   input wire fmc_pkg::fmc_op_t req_op,
   input wire logic [fmc_pkg::ADDR_W-1:0] req_addr,
   input wire logic [fmc_pkg::DATA_W-1:0] req_data,
   output logic req_ready,
   output logic rsp_valid,
   output logic [fmc_pkg::DATA_W-1:0] rsp_data,
   output logic [5:0] rsp_sector,
   output logic spm_active,
   output logic flash_busy,
   output logic [fmc_pkg::ADDR_W-1:0] word_address_lines,
   output logic [fmc_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe_n,
   input wire logic [fmc_pkg::DATA_W-1:0] data_lines_in,
   output logic chip_sel_n,
   output logic out_en_n,
   output logic wr_strobe_n,
   output logic flash_reset_n,
   input wire logic ready_busy_n
);
   import fmc_pkg::*;

   logic rst_s1, rst_n;
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // Two-flop sync of pins from the device
   // sixteen-bit data path
   logic [DATA_W-1:0] din_s1, din_s2;
   logic rdy_s1, rdy_s2;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         din_s1 <= '0;
         din_s2 <= '0;
         rdy_s1 <= 1'b1;
         rdy_s2 <= 1'b1;
      end
      else
      begin
         din_s1 <= data_lines_in;
         din_s2 <= din_s1;
         rdy_s1 <= ready_busy_n;
         rdy_s2 <= rdy_s1;
      end
   end

   // Sector index from word address; small sectors at chosen end
   function automatic logic [5:0] sector_of(input logic [ADDR_W-1:0] a);
      logic [5:0] s;
      s = '0;
      if (BOOT_TOP)
      begin
         if (a[ADDR_W-1:LARGE_SHIFT] == 5'(LARGE_SECTORS))
            s = 6'(LARGE_SECTORS) + 6'(a[LARGE_SHIFT-1:SMALL_SHIFT]);
         else
            s = 6'(a[ADDR_W-1:LARGE_SHIFT]);
      end
      else
      begin
         if (a[ADDR_W-1:LARGE_SHIFT] == 5'h0_0)
            s = 6'(a[LARGE_SHIFT-1:SMALL_SHIFT]);
         else
            s = 6'(SMALL_SECTORS) + 6'(a[ADDR_W-1:LARGE_SHIFT]) - 6'h0_01;
      end
      return s;
   endfunction

   // Write sequence table: up to six bus cycles
   logic [ADDR_W-1:0] seq_a [0:5];
   logic [DATA_W-1:0] seq_d [0:5];
   logic [2:0] seq_len, next_seq_len, seq_idx, next_seq_idx;
   logic [ADDR_W-1:0] next_seq_a [0:5];
   logic [DATA_W-1:0] next_seq_d [0:5];
   fmc_state_t state, next_state;
   logic [CNT_W-1:0] cnt, next_cnt;
   logic spm, next_spm;
   logic req_ready_q, next_req_ready;
   logic rsp_valid_q, next_rsp_valid;
   logic [DATA_W-1:0] rsp_data_q, next_rsp_data;
   logic [5:0] rsp_sec_q, next_rsp_sec;
   logic [ADDR_W-1:0] addr_q, next_addr;
   logic [DATA_W-1:0] dout_q, next_dout;
   logic oe_dat_n, next_oe_dat_n, ce_n, next_ce_n, oe_n, next_oe_n;
   logic we_n, next_we_n, frst_n, next_frst_n;

   always_comb
   begin
      next_state = state;
      next_cnt = cnt;
      next_spm = spm;
      next_seq_len = seq_len;
      next_seq_idx = seq_idx;
      next_seq_a = seq_a;
      next_seq_d = seq_d;
      next_req_ready = 1'b0;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data_q;
      next_rsp_sec = rsp_sec_q;
      next_addr = addr_q;
      next_dout = dout_q;
      next_oe_dat_n = oe_dat_n;
      next_ce_n = ce_n;
      next_oe_n = oe_n;
      next_we_n = we_n;
      next_frst_n = frst_n;
      case (state)
         FMC_IDLE:
         begin
            next_req_ready = 1'b1;
            if (req_valid && req_ready_q)
            begin
               next_req_ready = 1'b0;
               next_seq_idx = '0;
               next_rsp_sec = sector_of(req_addr);
               next_cnt = '0;
               // program outside single pulse mode, erase, lock and SPM entry are written unlock sequences; SPM exit is a reset pulse
               next_seq_a[0] = UNLOCK_A1;
               next_seq_d[0] = UNLOCK_D1;
               next_seq_a[1] = UNLOCK_A2;
               next_seq_d[1] = UNLOCK_D2;
               next_seq_a[2] = UNLOCK_A1;
               next_seq_a[3] = UNLOCK_A1;
               next_seq_d[3] = UNLOCK_D1;
               next_seq_a[4] = UNLOCK_A2;
               next_seq_d[4] = UNLOCK_D2;
               next_seq_a[5] = req_addr;
               next_seq_d[5] = req_data;
               next_seq_len = 3'h4;
               case (req_op)
                  FMC_OP_READ:
                  begin
                     next_addr = req_addr;
                     next_state = FMC_RD_LOW;
                  end
                  FMC_OP_PROGRAM:
                  begin
                     // single strobe when in single pulse mode
                     if (spm)
                     begin
                        next_seq_a[0] = req_addr;
                        next_seq_d[0] = req_data;
                        next_seq_len = 3'h1;
                     end
                     else
                     begin
                        next_seq_d[2] = CMD_PROGRAM;
                        next_seq_a[3] = req_addr;
                        next_seq_d[3] = req_data;
                     end
                     next_state = FMC_WR_SETUP;
                  end
                  FMC_OP_SECTOR_ERASE, FMC_OP_CHIP_ERASE, FMC_OP_LOCK_SECTOR:
                  begin
                     // in single pulse mode this word is programmed
                     next_seq_d[2] = (req_op == FMC_OP_LOCK_SECTOR) ? CMD_LOCK : CMD_ERASE;
                     next_seq_d[5] = (req_op == FMC_OP_SECTOR_ERASE) ? CMD_SECTOR
                                   : (req_op == FMC_OP_CHIP_ERASE) ? CMD_CHIP : req_data;
                     if (req_op == FMC_OP_CHIP_ERASE)
                        next_seq_a[5] = UNLOCK_A1;
                     next_seq_len = 3'h6;
                     next_state = FMC_WR_SETUP;
                  end
                  FMC_OP_SUSPEND, FMC_OP_RESUME:
                  begin
                     // suspend and resume are each a single command write to the request address
                     next_seq_a[0] = req_addr;
                     next_seq_d[0] = (req_op == FMC_OP_SUSPEND) ? CMD_SUSPEND : CMD_RESUME;
                     next_seq_len = 3'h1;
                     next_state = FMC_WR_SETUP;
                  end
                  FMC_OP_SPM_ENTER:
                  begin
                     next_seq_d[2] = CMD_ERASE;
                     next_seq_a[5] = UNLOCK_A1;
                     next_seq_d[5] = CMD_SPM;
                     next_seq_len = 3'h6;
                     next_state = FMC_WR_SETUP;
                  end
                  default:
                  begin
                     next_frst_n = 1'b0;
                     next_state = FMC_RST_LOW;
                  end
               endcase
            end
         end
         FMC_WR_SETUP:
         begin
            // no sequence starts while device reports busy; later writes do not check
            if (rdy_s2)
            begin
               // address before strobes fall, oe high
               next_addr = seq_a[seq_idx];
               next_dout = seq_d[seq_idx];
               next_oe_dat_n = 1'b0;
               next_oe_n = 1'b1;
               next_cnt = '0;
               next_state = FMC_WR_LOW;
            end
         end
         FMC_WR_LOW:
         begin
            next_cnt = cnt + 1'b1;
            // Strobes fall a cycle after address, so it is set up
            next_ce_n = 1'b0;
            next_we_n = 1'b0;
            if (cnt == CNT_W'(WE_LOW_CYC))
            begin
               // data latched on this rising edge
               next_we_n = 1'b1;
               next_cnt = '0;
               next_state = FMC_WR_HIGH;
            end
         end
         FMC_WR_HIGH:
         begin
            next_cnt = cnt + 1'b1;
            next_ce_n = 1'b1;
            if (cnt == CNT_W'(WE_HIGH_CYC - 1))
            begin
               next_seq_idx = seq_idx + 1'b1;
               next_state = (seq_idx + 1'b1 == seq_len) ? FMC_DONE : FMC_WR_LOW;
               next_oe_dat_n = (seq_idx + 1'b1 == seq_len);
               next_cnt = '0;
               // Table has six slots; never index past the last one
               if (seq_idx + 1'b1 != seq_len)
               begin
                  next_addr = seq_a[3'(seq_idx + 1'b1)];
                  next_dout = seq_d[3'(seq_idx + 1'b1)];
               end
               // Lock data may equal the entry code; check the third word too
               if (seq_len == 3'h6 && seq_d[2] == CMD_ERASE && seq_d[5] == CMD_SPM
                   && seq_idx == 3'h5)
                  next_spm = 1'b1;
            end
         end
         FMC_RD_LOW:
         begin
            // bus released, device drives on read
            next_oe_dat_n = 1'b1;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(READ_CYC + 2))
            begin
               // polled and toggle bits return in data
               next_rsp_data = din_s2;
               next_ce_n = 1'b1;
               next_oe_n = 1'b1;
               next_state = FMC_DONE;
            end
         end
         FMC_RST_LOW:
         begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(RST_LOW_CYC))
            begin
               next_frst_n = 1'b1;
               next_spm = 1'b0;
               next_cnt = '0;
               next_state = FMC_RST_REC;
            end
         end
         FMC_RST_REC:
         begin
            next_cnt = cnt + 1'b1;
            if (cnt == CNT_W'(RST_REC_CYC - 1))
               next_state = FMC_DONE;
         end
         FMC_DONE:
         begin
            next_rsp_valid = 1'b1;
            next_state = FMC_IDLE;
         end
         default:
            next_state = FMC_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= FMC_IDLE;
         cnt <= '0;
         spm <= 1'b0;
         seq_len <= '0;
         seq_idx <= '0;
         for (int i = 0; i < 6; i++)
         begin
            seq_a[i] <= '0;
            seq_d[i] <= '0;
         end
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= '0;
         rsp_sec_q <= '0;
         addr_q <= '0;
         dout_q <= '0;
         oe_dat_n <= 1'b1;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         frst_n <= 1'b1;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         spm <= next_spm;
         seq_len <= next_seq_len;
         seq_idx <= next_seq_idx;
         seq_a <= next_seq_a;
         seq_d <= next_seq_d;
         req_ready_q <= next_req_ready;
         rsp_valid_q <= next_rsp_valid;
         rsp_data_q <= next_rsp_data;
         rsp_sec_q <= next_rsp_sec;
         addr_q <= next_addr;
         dout_q <= next_dout;
         oe_dat_n <= next_oe_dat_n;
         ce_n <= next_ce_n;
         oe_n <= next_oe_n;
         we_n <= next_we_n;
         frst_n <= next_frst_n;
      end
   end

   logic busy_q;
   always_ff @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
         busy_q <= 1'b0;
      else
         busy_q <= ~rdy_s2;
   end

   assign req_ready = req_ready_q;
   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_data_q;
   assign rsp_sector = rsp_sec_q;
   assign spm_active = spm;
   assign flash_busy = busy_q;
   assign word_address_lines = addr_q;
   assign data_lines_out = dout_q;
   assign data_lines_oe_n = oe_dat_n;
   assign chip_sel_n = ce_n;
   assign out_en_n = oe_n;
   assign wr_strobe_n = we_n;
   assign flash_reset_n = frst_n;
endmodule

//--- fmc_ctrl_asserts.sv
`timescale 1ns/1ps
module fmc_ctrl_asserts
   import fmc_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic rsp_valid,
   input wire logic [5:0] rsp_sector,
   input wire logic flash_busy,
   input wire logic [fmc_pkg::ADDR_W-1:0] word_address_lines,
   input wire logic [fmc_pkg::DATA_W-1:0] data_lines_out,
   input wire logic data_lines_oe_n,
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_strobe_n,
   input wire logic flash_reset_n,
   input wire logic ready_busy_n
);
   logic [7:0] rst_cnt;
   logic [7:0] next_rst_cnt;
   // Saturates so a long pulse cannot wrap
   always_comb
      next_rst_cnt = flash_reset_n ? 8'h00 : rst_cnt + {7'h00, rst_cnt != 8'hFF};
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
         rst_cnt <= 8'h00;
      else
         rst_cnt <= next_rst_cnt;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_read_no_drive: assert property (!out_en_n |-> data_lines_oe_n)
      else $error("host drives data lines during a read");
   a_write_pins: assert property (!wr_strobe_n |-> out_en_n && !chip_sel_n && !data_lines_oe_n)
      else $error("write strobe without proper select and enables");
   a_write_hold: assert property (!wr_strobe_n && !$past(wr_strobe_n)
      |-> $stable(word_address_lines) && $stable(data_lines_out))
      else $error("address or data moved during write strobe");
   a_addr_setup: assert property ($fell(wr_strobe_n) |-> $stable(word_address_lines))
      else $error("address changed as write strobe fell");
   a_data_setup: assert property ($fell(wr_strobe_n) |-> $stable(data_lines_out))
      else $error("data changed as write strobe fell");
   a_strobe_width: assert property ($fell(wr_strobe_n) |-> !wr_strobe_n [*8])
      else $error("write strobe too short");
   a_reset_float: assert property (!flash_reset_n |-> chip_sel_n && wr_strobe_n
      && out_en_n && data_lines_oe_n)
      else $error("bus active while flash reset low");
   a_reset_width: assert property ($rose(flash_reset_n) |-> rst_cnt >= 8'h64)
      else $error("flash reset pulse shorter than 500 ns");
   a_busy_follow: assert property (!ready_busy_n [*3] |=> flash_busy)
      else $error("busy not reported");
   a_ready_follow: assert property (ready_busy_n [*3] |=> !flash_busy)
      else $error("busy reported while flash ready");
   a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
      else $error("response longer than one cycle");
   a_sector_range: assert property (rsp_valid |-> rsp_sector <= 6'h26)
      else $error("sector index out of range");
   c_reset_pulse: cover property ($rose(flash_reset_n));
   c_write: cover property ($rose(wr_strobe_n));
   c_read: cover property ($rose(out_en_n));
endmodule
bind fmc_ctrl fmc_ctrl_asserts u_asserts (
   .mclk(mclk), .resetn(resetn), .rsp_valid(rsp_valid), .rsp_sector(rsp_sector),
   .flash_busy(flash_busy), .word_address_lines(word_address_lines),
   .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n),
   .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
   .flash_reset_n(flash_reset_n), .ready_busy_n(ready_busy_n)
);

//--- fmc_flash_model.sv
`timescale 1ns/1ps
module fmc_flash_model
   import fmc_pkg::*;
#(
   parameter bit BOOT_TOP = 1'b1,
   parameter int PROG_NS = 300,
   parameter int ERASE_NS = 600
)
(
   input wire logic chip_sel_n,
   input wire logic out_en_n,
   input wire logic wr_strobe_n,
   input wire logic flash_reset_n,
   input wire logic vpp_ok,
   input wire logic [fmc_pkg::ADDR_W-1:0] word_address_lines,
   input wire logic [fmc_pkg::DATA_W-1:0] data_lines,
   output logic [fmc_pkg::DATA_W-1:0] data_lines_in,
   output logic ready_busy_n,
   output logic spm,
   output int n_wr
);
   // sparse array, erased words read ones
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   logic [ADDR_W-1:0] a_lat;
   logic [ADDR_W-1:0] keys [$];
   int step = 0;
   int busy_ns = 0;
   bit prog = 0;
   realtime t_rst = 0;
   initial
   begin
      spm = 1'b0;
      n_wr = 0;
      data_lines_in = 16'h0000;
   end
   function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   function automatic int sect(input logic [ADDR_W-1:0] a);
      if (BOOT_TOP)
         return (a[19:15] == 5'h1F) ? 31 + a[14:12] : a[19:15];
      return (a[19:15] == 5'h00) ? a[14:12] : 7 + a[19:15];
   endfunction
   assign ready_busy_n = (busy_ns == 0);
   always #1
      if (busy_ns > 0)
         busy_ns--;
   // address at fall, data at rise
   always @(negedge wr_strobe_n)
      a_lat = word_address_lines;
   always @(posedge wr_strobe_n)
      if (!chip_sel_n && out_en_n && flash_reset_n)
         take(a_lat, data_lines);
   task automatic take(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      n_wr++;
      if (prog || spm)
      begin
         prog = 0;
         if (vpp_ok)
         begin
            mem[a] = rd(a) & d;
            busy_ns = PROG_NS;
         end
         return;
      end
      case (step)
         0, 3: step = (a == UNLOCK_A1 && d == UNLOCK_D1) ? step + 1 : 0;
         1, 4: step = (a == UNLOCK_A2 && d == UNLOCK_D2) ? step + 1 : 0;
         2:
         begin
            prog = (d == CMD_PROGRAM);
            step = (d == CMD_ERASE) ? 3 : 0;
         end
         default:
         begin
            step = 0;
            spm = spm | (d == CMD_SPM);
            if (vpp_ok && (d == CMD_CHIP || d == CMD_SECTOR))
            begin
               keys.delete();
               foreach (mem[k])
                  if (d == CMD_CHIP || sect(k) == sect(a))
                     keys.push_back(k);
               foreach (keys[i])
                  mem.delete(keys[i]);
               busy_ns = ERASE_NS;
            end
         end
      endcase
   endtask
   always @(negedge flash_reset_n)
   begin
      t_rst = $realtime;
      step = 0;
      prog = 0;
      busy_ns = 0;
   end
   always @(posedge flash_reset_n)
      if ($realtime - t_rst >= 500.0)
         spm = 1'b0;
   // released bus shows a moving pattern
   always @(chip_sel_n, out_en_n, wr_strobe_n, flash_reset_n, word_address_lines, n_wr)
      data_lines_in = (!chip_sel_n && !out_en_n && wr_strobe_n && flash_reset_n)
         ? rd(word_address_lines) : ~data_lines_in;
endmodule

//--- fmc_ctrl_test.sv
`timescale 1ns/1ps
module fmc_ctrl_test;
   import fmc_pkg::*;
   logic mclk, resetn, req_valid, req_ready, rsp_valid, spm_active, flash_busy, vpp_ok;
   fmc_op_t req_op;
   logic [ADDR_W-1:0] req_addr, word_address_lines;
   logic [DATA_W-1:0] req_data, rsp_data, data_lines_out, bus, model_q, got_data;
   logic [5:0] rsp_sector, got_sect;
   logic data_lines_oe_n, chip_sel_n, out_en_n, wr_strobe_n, flash_reset_n, ready_busy_n;
   logic model_spm, saw_busy;
   int n_wr, n_mismatch, n_tests;
   // Host drives the wire only with its enable low
   assign bus = data_lines_oe_n ? model_q : data_lines_out;
   fmc_ctrl #(.BOOT_TOP(1'b1)) dut (
      .mclk(mclk), .resetn(resetn), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_sector(rsp_sector),
      .spm_active(spm_active), .flash_busy(flash_busy),
      .word_address_lines(word_address_lines), .data_lines_out(data_lines_out),
      .data_lines_oe_n(data_lines_oe_n), .data_lines_in(bus), .chip_sel_n(chip_sel_n),
      .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .flash_reset_n(flash_reset_n),
      .ready_busy_n(ready_busy_n)
   );
   fmc_flash_model #(.BOOT_TOP(1'b1)) flash (
      .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
      .flash_reset_n(flash_reset_n), .vpp_ok(vpp_ok), .word_address_lines(word_address_lines),
      .data_lines(bus), .data_lines_in(model_q), .ready_busy_n(ready_busy_n),
      .spm(model_spm), .n_wr(n_wr)
   );
   initial
   begin
      mclk = 1'b0;
      forever
         #2.5 mclk = ~mclk;
   end
   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic req(input fmc_op_t op, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
      int i;
      @(posedge mclk);
      #1;
      req_valid = 1'b1;
      req_op = op;
      req_addr = a;
      req_data = d;
      for (i = 0; i < 400 && req_ready !== 1'b1; i++)
         @(negedge mclk);
      check("req_ready wait", 1, i < 400);
      if (i >= 400)
         end_sim();
      @(posedge mclk);
      #1;
      req_valid = 1'b0;
      saw_busy = 1'b0;
      for (i = 0; i < 4000 && rsp_valid !== 1'b1; i++)
      begin
         @(negedge mclk);
         saw_busy |= (flash_busy === 1'b1);
      end
      check("rsp_valid wait", 1, i < 4000);
      if (i >= 4000)
         end_sim();
      got_data = rsp_data;
      got_sect = rsp_sector;
   endtask
   task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      req(FMC_OP_READ, a, 16'h0000);
      check("read word", exp, got_data);
   endtask
   task automatic t_power_up();
      read_chk(20'hF_FFFF, 16'hFFFF);
      check("sector", 6'h26, got_sect);
      read_chk(20'h0_0000, 16'hFFFF);
      check("sector", 6'h00, got_sect);
      $display("test power_up done");
   endtask
   task automatic t_program();
      int w;
      w = n_wr;
      req(FMC_OP_PROGRAM, 20'h1_2345, 16'h1234);
      check("program writes", 4, n_wr - w);
      check("busy seen", 1, saw_busy);
      read_chk(20'h1_2345, 16'h1234);
      check("sector", 6'h02, got_sect);
      vpp_ok = 1'b0;
      req(FMC_OP_PROGRAM, 20'h0_0100, 16'h0000);
      vpp_ok = 1'b1;
      read_chk(20'h0_0100, 16'hFFFF);
      $display("test program done");
   endtask
   task automatic t_erase();
      int w;
      req(FMC_OP_PROGRAM, 20'hF_8000, 16'h00F0);
      check("sector", 6'h1F, got_sect);
      req(FMC_OP_PROGRAM, 20'hF_9000, 16'h0F00);
      check("sector", 6'h20, got_sect);
      w = n_wr;
      req(FMC_OP_SECTOR_ERASE, 20'hF_8000, 16'h0000);
      check("erase writes", 6, n_wr - w);
      read_chk(20'hF_8000, 16'hFFFF);
      read_chk(20'hF_9000, 16'h0F00);
      read_chk(20'h1_2345, 16'h1234);
      req(FMC_OP_CHIP_ERASE, 20'h0_0000, 16'h0000);
      read_chk(20'h1_2345, 16'hFFFF);
      $display("test erase done");
   endtask
   task automatic t_spm();
      int w;
      req(FMC_OP_SPM_ENTER, 20'h0_0000, 16'h0000);
      check("spm active", 1, spm_active);
      check("device spm", 1, model_spm);
      w = n_wr;
      req(FMC_OP_PROGRAM, 20'h0_0200, CMD_SECTOR);
      check("spm writes", 1, n_wr - w);
      read_chk(20'h0_0200, CMD_SECTOR);
      req(FMC_OP_SPM_EXIT, 20'h0_0000, 16'h0000);
      check("spm active", 0, spm_active);
      check("device spm", 0, model_spm);
      w = n_wr;
      req(FMC_OP_PROGRAM, 20'h0_0300, 16'h5A5A);
      check("program writes", 4, n_wr - w);
      $display("test spm done");
   endtask
   task automatic t_misc();
      fmc_op_t ops [3] = '{FMC_OP_SUSPEND, FMC_OP_RESUME, FMC_OP_LOCK_SECTOR};
      int w;
      w = n_wr;
      foreach (ops[i])
         req(ops[i], 20'h0_0300, 16'h0000);
      check("command writes", 8, n_wr - w);
      read_chk(20'h0_0300, 16'h5A5A);
      @(posedge mclk);
      #1;
      resetn = 1'b0;
      repeat (2)
         @(posedge mclk);
      #1;
      resetn = 1'b1;
      read_chk(20'h0_0300, 16'h5A5A);
      $display("test misc done");
   endtask
   initial
   begin
      resetn = 1'b0;
      req_valid = 1'b0;
      req_op = FMC_OP_READ;
      req_addr = 20'h0_0000;
      req_data = 16'h0000;
      vpp_ok = 1'b1;
      n_mismatch = 0;
      n_tests = 0;
      repeat (6)
         @(posedge mclk);
      #1;
      resetn = 1'b1;
      t_power_up();
      t_program();
      t_erase();
      t_spm();
      t_misc();
      end_sim();
   end
endmodule
